// ===== design/wdk_pkg.sv
package wdk_pkg;
  // ----------------------------------------------------------------
  // Register map (word offsets, byte addresses)
  // ----------------------------------------------------------------
  localparam logic [3:0] ADDR_CONFIG = 4'h0;
  localparam logic [3:0] ADDR_KEYFLAGS = 4'h4;
  localparam logic [3:0] ADDR_COUNT = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;
  // ----------------------------------------------------------------
  // Field codes and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] KEY_ENABLE = 5'h0a;
  localparam logic [4:0] KEY_ALT = 5'h15;
  localparam logic [2:0] SCALE_RST = 3'h7;
  localparam logic [1:0] RC_EN_RST = 2'h2;
  localparam logic [1:0] RC_DISABLE = 2'h1;
  localparam logic [1:0] SUPPLY_RST = 2'h1;
  localparam logic [1:0] SUPPLY_REG = 2'h2;
  localparam int SCALE_BASE = 8;
  localparam int CNT_W = 16;
  localparam logic [1:0] SRC_RC = 2'h0;
  localparam logic [1:0] SRC_XTAL = 2'h1;
  localparam logic [1:0] SRC_INSTR = 2'h2;
  localparam logic [1:0] INSTR_DIV = 2'h3;
  localparam logic [1:0] KEY_RST_DLY = 2'h2;
  // Source frequencies, informative only
  localparam int SLOW_RC_HZ = 12000;
  localparam int XTAL_HZ = 32768;
  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [2:0] scale;
    logic [1:0] rc_en;
    logic [1:0] supply;
  } wdk_cfg_t;
  typedef struct packed {
    logic single_clr;
    logic pair_first;
    logic pair_second;
    logic halt;
  } wdk_cpu_t;
endpackage

// ===== design/wdk_watchdog.sv
`timescale 1ns/1ps
module wdk_watchdog #(
  parameter bit ALWAYS_ON = 1'b0,
  parameter bit PAIRED_CLEAR = 1'b0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Clock sources and pins
  input wire logic slow_rc_tick,
  input wire logic xtal_tick,
  input wire logic [1:0] src_sel,
  input wire logic external_reset_pin_n,
  input wire logic lv_reset_event,
  input wire logic lv_setting_event,
  input wire wdk_pkg::wdk_cpu_t cpu,
  input wire logic wake,
  // Outputs
  output logic device_reset,
  output logic warm_reset,
  output logic slow_rc_on,
  output logic supply_regulator
);
  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  wdk_pkg::wdk_cfg_t cfg_r;
  logic [4:0] key_r;
  logic lvr_flag_r, lvs_flag_r, key_reset_flag_r;
  logic timeout_flag_r, powerdown_flag_r;
  logic [wdk_pkg::CNT_W-1:0] cnt_r;
  logic [1:0] instr_div_r;
  logic pair_first_seen_r, pair_second_seen_r;
  logic key_bad_pend_r;
  logic [1:0] key_dly_r;
  logic pd_r;

  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire wr = req && wb_we_i;
  wire wr_cfg = wr && wb_adr_i == wdk_pkg::ADDR_CONFIG && wb_sel_i[0];
  wire wr_key = wr && wb_adr_i == wdk_pkg::ADDR_KEYFLAGS && wb_sel_i[0];
  wire wr_cnt = wr && wb_adr_i == wdk_pkg::ADDR_COUNT && wb_sel_i[0];
  wire [4:0] new_key = wb_dat_i[7:3];
  wire key_valid = new_key == wdk_pkg::KEY_ENABLE || new_key == wdk_pkg::KEY_ALT;

  // ----------------------------------------------------------------
  // Enable decode
  // ----------------------------------------------------------------
  wire wd_enabled = ALWAYS_ON || key_r != wdk_pkg::KEY_ALT;
  wire rc_running = cfg_r.rc_en != wdk_pkg::RC_DISABLE;

  // Source tick select; disabled slow RC gives no ticks
  logic src_tick;
  always_comb begin
    case (src_sel)
      wdk_pkg::SRC_RC: src_tick = slow_rc_tick && rc_running;
      wdk_pkg::SRC_XTAL: src_tick = xtal_tick;
      // System clock halts in power-down, so this source stops there
      wdk_pkg::SRC_INSTR: src_tick = instr_div_r == wdk_pkg::INSTR_DIV && !pd_r;
      default: src_tick = 1'b0;
    endcase
  end

  wire [wdk_pkg::CNT_W-1:0] ratio = wdk_pkg::CNT_W'(1) << (wdk_pkg::SCALE_BASE + int'(cfg_r.scale));
  wire overflow = wd_enabled && src_tick && (cnt_r + 1'b1) >= ratio;

  wire pair_done = (pair_first_seen_r || cpu.pair_first) && (pair_second_seen_r || cpu.pair_second);
  wire sw_clear = PAIRED_CLEAR ? pair_done : cpu.single_clr;
  wire cnt_clear = !external_reset_pin_n || sw_clear || cpu.halt;

  // ----------------------------------------------------------------
  // Instruction clock divider
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      instr_div_r <= 2'h0;
    end else begin
      instr_div_r <= instr_div_r + 2'h1;
    end
  end

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_r <= '0;
    end else if (cnt_clear || overflow) begin
      cnt_r <= '0;
    end else if (wr_cnt && !wd_enabled) begin
      cnt_r <= '0;
    end else if (src_tick) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || sw_clear || !PAIRED_CLEAR) begin
      pair_first_seen_r <= 1'b0;
      pair_second_seen_r <= 1'b0;
    end else begin
      pair_first_seen_r <= pair_first_seen_r | cpu.pair_first;
      pair_second_seen_r <= pair_second_seen_r | cpu.pair_second;
    end
  end

  // ----------------------------------------------------------------
  // Power-down state
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      pd_r <= 1'b0;
    end else if (cpu.halt) begin
      pd_r <= 1'b1;
    end else if (wake || overflow) begin
      pd_r <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      timeout_flag_r <= 1'b0;
      powerdown_flag_r <= 1'b0;
    end else begin
      if (overflow) begin
        timeout_flag_r <= 1'b1;
      end else if (cpu.halt) begin
        timeout_flag_r <= 1'b0;
      end
      if (cpu.halt) begin
        powerdown_flag_r <= 1'b1;
      end else if (cpu.single_clr) begin
        powerdown_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Config and key registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= '{scale: wdk_pkg::SCALE_RST, rc_en: wdk_pkg::RC_EN_RST, supply: wdk_pkg::SUPPLY_RST};
    end else if (wr_cfg) begin
      cfg_r <= '{scale: wb_dat_i[7:5], rc_en: wb_dat_i[3:2], supply: wb_dat_i[1:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      key_r <= wdk_pkg::KEY_ENABLE;
    end else if (wr_key) begin
      key_r <= new_key;
    end
  end

  // Flags: hardware set beats software clear; software writes only zeros
  always_ff @(posedge clk) begin
    if (rst) begin
      lvr_flag_r <= 1'b0;
      lvs_flag_r <= 1'b0;
      key_reset_flag_r <= 1'b0;
    end else begin
      if (lv_reset_event) begin
        lvr_flag_r <= 1'b1;
      end else if (wr_key && !wb_dat_i[2]) begin
        lvr_flag_r <= 1'b0;
      end
      if (lv_setting_event) begin
        lvs_flag_r <= 1'b1;
      end else if (wr_key && !wb_dat_i[1]) begin
        lvs_flag_r <= 1'b0;
      end
      if (wr_key && !key_valid) begin
        key_reset_flag_r <= 1'b1;
      end else if (wr_key && !wb_dat_i[0]) begin
        key_reset_flag_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Invalid-key reset delay, counted in slow RC ticks
  // ----------------------------------------------------------------
  // Tick phase is unknown at the write, giving the 2 to 3 cycle spread
  always_ff @(posedge clk) begin
    if (rst) begin
      key_bad_pend_r <= 1'b0;
      key_dly_r <= 2'h0;
    end else if (wr_key && !key_valid) begin
      key_bad_pend_r <= 1'b1;
      key_dly_r <= 2'h0;
    end else if (key_bad_pend_r && slow_rc_tick) begin
      if (key_dly_r == wdk_pkg::KEY_RST_DLY) begin
        key_bad_pend_r <= 1'b0;
      end else begin
        key_dly_r <= key_dly_r + 2'h1;
      end
    end
  end
  wire key_fire = key_bad_pend_r && slow_rc_tick && key_dly_r == wdk_pkg::KEY_RST_DLY;

  // ----------------------------------------------------------------
  // Reset outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      device_reset <= 1'b0;
      warm_reset <= 1'b0;
    end else begin
      device_reset <= key_fire || (overflow && !pd_r);
      warm_reset <= overflow && pd_r;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      slow_rc_on <= 1'b1;
      supply_regulator <= 1'b0;
    end else begin
      slow_rc_on <= rc_running;
      supply_regulator <= cfg_r.supply == wdk_pkg::SUPPLY_REG;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer: one wait-state ack, unmapped reads zero
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= '0;
      if (req && !wb_we_i) begin
        case (wb_adr_i)
          wdk_pkg::ADDR_CONFIG: wb_dat_o[7:0] <= {cfg_r.scale, 1'b0, cfg_r.rc_en, cfg_r.supply};
          wdk_pkg::ADDR_KEYFLAGS: wb_dat_o[7:0] <= {key_r, lvr_flag_r, lvs_flag_r, key_reset_flag_r};
          wdk_pkg::ADDR_COUNT: wb_dat_o[7:0] <= cnt_r[11:4];
          wdk_pkg::ADDR_STATUS: wb_dat_o[2:0] <= {pd_r, powerdown_flag_r, timeout_flag_r};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // A pending bad-key reset may still fire while disabled
  a_disabled_no_reset: assert property (@(posedge clk) disable iff (rst)
    !wd_enabled |=> !warm_reset && device_reset == $past(key_fire))
    else $error("counter reset while disabled");
  a_key_flag_set: assert property (@(posedge clk) disable iff (rst)
    (wr_key && !key_valid) |=> key_reset_flag_r && key_bad_pend_r)
    else $error("bad key not flagged");
  a_full_reset: assert property (@(posedge clk) disable iff (rst)
    (overflow && !pd_r) |=> device_reset && timeout_flag_r && !warm_reset)
    else $error("no full reset");
  a_warm_reset: assert property (@(posedge clk) disable iff (rst)
    (overflow && pd_r) |=> warm_reset && device_reset == $past(key_fire))
    else $error("no warm reset");
  a_clear_counter: assert property (@(posedge clk) disable iff (rst)
    cnt_clear |=> cnt_r == '0)
    else $error("counter not cleared");
  a_halt_flags: assert property (@(posedge clk) disable iff (rst)
    (cpu.halt && !overflow) |=> powerdown_flag_r && !timeout_flag_r)
    else $error("halt flags wrong");
  a_rc_stopped: assert property (@(posedge clk) disable iff (rst)
    (cfg_r.rc_en == wdk_pkg::RC_DISABLE && src_sel == wdk_pkg::SRC_RC) |-> !src_tick)
    else $error("rc ticks");
  a_view_bits: assert property (@(posedge clk) disable iff (rst)
    (req && !wb_we_i && wb_adr_i == wdk_pkg::ADDR_COUNT) |=> wb_dat_o[7:0] == $past(cnt_r[11:4]))
    else $error("count view wrong");
  a_supply_sel: assert property (@(posedge clk) disable iff (rst)
    ##1 supply_regulator == ($past(cfg_r.supply) == wdk_pkg::SUPPLY_REG))
    else $error("supply select wrong");
  a_pd_stop: assert property (@(posedge clk) disable iff (rst)
    (pd_r && src_sel == wdk_pkg::SRC_INSTR) |-> !src_tick)
    else $error("instr clock ticks in power-down");
  a_xtal_source: assert property (@(posedge clk) disable iff (rst)
    (src_sel == wdk_pkg::SRC_XTAL) |-> src_tick == xtal_tick)
    else $error("crystal tick not passed");
  a_key_alt_mode: assert property (@(posedge clk) disable iff (rst)
    (wr_key && new_key == wdk_pkg::KEY_ALT) |=> wd_enabled == ALWAYS_ON)
    else $error("alternate key mode wrong");
  a_key_enable: assert property (@(posedge clk) disable iff (rst)
    (wr_key && new_key == wdk_pkg::KEY_ENABLE) |=> wd_enabled)
    else $error("enable key ignored");
  a_key_fire: assert property (@(posedge clk) disable iff (rst)
    key_fire |=> device_reset)
    else $error("bad key reset missing");
  a_ratio_reached: assert property (@(posedge clk) disable iff (rst)
    overflow |-> (cnt_r >> cfg_r.scale) >= 16'h00ff)
    else $error("overflow before ratio");
  a_count_write: assert property (@(posedge clk) disable iff (rst)
    (wr_cnt && !wd_enabled) |=> cnt_r == '0)
    else $error("disabled counter not cleared by write");
  a_count_keep: assert property (@(posedge clk) disable iff (rst)
    (wr_cnt && wd_enabled && !cnt_clear && !src_tick) |=> $stable(cnt_r))
    else $error("enabled counter changed by write");
  a_rc_enable: assert property (@(posedge clk) disable iff (rst)
    (cfg_r.rc_en == wdk_pkg::RC_DISABLE) |=> !slow_rc_on)
    else $error("slow rc left on");
  a_key_poweron: assert property (@(posedge clk)
    rst |=> key_r == wdk_pkg::KEY_ENABLE && cnt_r == '0)
    else $error("power-on key or count wrong");
  a_lv_set: assert property (@(posedge clk) disable iff (rst)
    lv_reset_event |=> lvr_flag_r)
    else $error("low-voltage flag not set");
  a_lv_no_set: assert property (@(posedge clk) disable iff (rst)
    (!lv_reset_event && !lv_setting_event && !lvr_flag_r && !lvs_flag_r) |=> !lvr_flag_r && !lvs_flag_r)
    else $error("low-voltage flag set without event");
  a_pd_entry: assert property (@(posedge clk) disable iff (rst)
    cpu.halt |=> cnt_r == '0 && pd_r)
    else $error("power-down entry wrong");
endmodule

// ===== verif/test_watchdog_timer_keyed.sv
`timescale 1ns/1ps
module test_watchdog_timer_keyed;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [3:0] wb_adr_i = 4'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic slow_rc_tick = 1'b0;
  logic xtal_tick = 1'b0;
  logic [1:0] src_sel = 2'h0;
  logic external_reset_pin_n = 1'b1;
  logic lv_reset_event = 1'b0;
  logic lv_setting_event = 1'b0;
  wdk_pkg::wdk_cpu_t cpu = '0;
  logic wake = 1'b0;
  logic device_reset;
  logic warm_reset;
  logic slow_rc_on;
  logic supply_regulator;
  int miscompares = 0;
  int comparisons = 0;
  int n_dev = 0;
  int n_warm = 0;
  int n_dev_p = 0;
  logic [31:0] v;
  logic [31:0] pv;
  logic [31:0] p_dat;
  logic p_dev;

  always #5 clk = ~clk;

  wdk_watchdog dut_u (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .slow_rc_tick(slow_rc_tick), .xtal_tick(xtal_tick), .src_sel(src_sel),
    .external_reset_pin_n(external_reset_pin_n), .lv_reset_event(lv_reset_event),
    .lv_setting_event(lv_setting_event), .cpu(cpu), .wake(wake), .device_reset(device_reset),
    .warm_reset(warm_reset), .slow_rc_on(slow_rc_on), .supply_regulator(supply_regulator));

  // Always-on, paired-clear build fed by the same stimulus
  wdk_watchdog #(.ALWAYS_ON(1'b1), .PAIRED_CLEAR(1'b1)) dut_p (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(p_dat), .wb_ack_o(), .slow_rc_tick(slow_rc_tick), .xtal_tick(xtal_tick), .src_sel(src_sel),
    .external_reset_pin_n(external_reset_pin_n), .lv_reset_event(lv_reset_event),
    .lv_setting_event(lv_setting_event), .cpu(cpu), .wake(wake), .device_reset(p_dev), .warm_reset(),
    .slow_rc_on(), .supply_regulator());

  // ----------------------------------------------------------------
  // Reset pulse counters
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    if (device_reset === 1'b1) n_dev++;
    if (warm_reset === 1'b1) n_warm++;
    if (p_dev === 1'b1) n_dev_p++;
  end

  task automatic print_verdict();
    if (miscompares == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("BAD %s expected %h got %h", name, exp, got);
      miscompares++;
    end
  endtask

  // ----------------------------------------------------------------
  // Classic Wishbone single cycle, waits for ack under a bound
  // ----------------------------------------------------------------
  task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat, output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= dat;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) chk("ack", 32'h1, 32'h0);
    rd = wb_dat_o;
    pv = p_dat;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] adr, input logic [7:0] d);
    logic [31:0] x;
    wb(1'b1, adr, {24'h0, d}, x);
  endtask

  task automatic rdchk(input string name, input logic [3:0] adr, input logic [31:0] exp);
    logic [31:0] x;
    wb(1'b0, adr, 32'h0, x);
    chk(name, exp, x);
  endtask

  // Source tick pulses, one idle cycle between them
  task automatic tick(input int n, input logic slow);
    repeat (n) begin
      @(posedge clk);
      xtal_tick <= ~slow;
      slow_rc_tick <= slow;
      @(posedge clk);
      xtal_tick <= 1'b0;
      slow_rc_tick <= 1'b0;
    end
    repeat (2) @(posedge clk);
  endtask

  task automatic pulse_cpu(input wdk_pkg::wdk_cpu_t c);
    @(posedge clk);
    cpu <= c;
    @(posedge clk);
    cpu <= '0;
  endtask

  // Far longer than the whole sequence needs
  initial begin
    #400us;
    miscompares++;
    print_verdict();
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    rdchk("config", wdk_pkg::ADDR_CONFIG, 32'he9);
    rdchk("keyflags", wdk_pkg::ADDR_KEYFLAGS, 32'h50);
    rdchk("count", wdk_pkg::ADDR_COUNT, 32'h0);
    rdchk("unmapped", 4'h1, 32'h0);
    // Low-voltage flags: set by events, cleared by writing 0, kept by writing 1
    @(posedge clk);
    lv_reset_event <= 1'b1;
    lv_setting_event <= 1'b1;
    @(posedge clk);
    lv_reset_event <= 1'b0;
    lv_setting_event <= 1'b0;
    rdchk("lv_flags", wdk_pkg::ADDR_KEYFLAGS, 32'h56);
    wr(wdk_pkg::ADDR_KEYFLAGS, {wdk_pkg::KEY_ENABLE, 3'b100});
    rdchk("lv_clr_one", wdk_pkg::ADDR_KEYFLAGS, 32'h54);
    wr(wdk_pkg::ADDR_KEYFLAGS, {wdk_pkg::KEY_ENABLE, 3'b000});
    rdchk("lv_clr_all", wdk_pkg::ADDR_KEYFLAGS, 32'h50);
    // Every enable and supply code, slow RC still selected
    for (int c = 0; c < 4; c++) begin
      wr(wdk_pkg::ADDR_CONFIG, {3'h0, 1'b0, 2'(c), 2'(c)});
      rdchk("cfg_rb", wdk_pkg::ADDR_CONFIG, {24'h0, 3'h0, 1'b0, 2'(c), 2'(c)});
      chk("slow_rc_on", {31'h0, c != 1}, {31'h0, slow_rc_on});
      chk("supply_reg", {31'h0, c == 2}, {31'h0, supply_regulator});
    end
    wr(wdk_pkg::ADDR_CONFIG, 8'h09);
    src_sel <= wdk_pkg::SRC_XTAL;
    // Disabled: counts past the ratio without reset, readable, clearable
    wr(wdk_pkg::ADDR_KEYFLAGS, {wdk_pkg::KEY_ALT, 3'b111});
    tick(300, 1'b0);
    chk("no_reset_dis", 32'h0, n_dev);
    chk("always_on", 32'h1, n_dev_p);
    rdchk("count_300", wdk_pkg::ADDR_COUNT, 32'h12);
    chk("p_count_300", 32'h2, pv);
    @(posedge clk);
    external_reset_pin_n <= 1'b0;
    @(posedge clk);
    external_reset_pin_n <= 1'b1;
    rdchk("count_pin", wdk_pkg::ADDR_COUNT, 32'h0);
    tick(32, 1'b0);
    rdchk("count_32", wdk_pkg::ADDR_COUNT, 32'h2);
    // Slow RC source: stopped while disabled, counts once enabled
    wr(wdk_pkg::ADDR_CONFIG, 8'h04);
    src_sel <= wdk_pkg::SRC_RC;
    tick(32, 1'b1);
    rdchk("count_rc_off", wdk_pkg::ADDR_COUNT, 32'h2);
    wr(wdk_pkg::ADDR_CONFIG, 8'h09);
    tick(32, 1'b1);
    rdchk("count_rc", wdk_pkg::ADDR_COUNT, 32'h4);
    // Instruction clock: one tick per four system clocks
    src_sel <= wdk_pkg::SRC_INSTR;
    repeat (256) @(posedge clk);
    src_sel <= wdk_pkg::SRC_XTAL;
    rdchk("count_instr", wdk_pkg::ADDR_COUNT, 32'h8);
    wr(wdk_pkg::ADDR_COUNT, 8'h00);
    rdchk("count_clr", wdk_pkg::ADDR_COUNT, 32'h0);
    chk("p_count_kept", 32'h8, pv);
    // Enabled, scale 0: a clear instruction restarts the count
    wr(wdk_pkg::ADDR_KEYFLAGS, {wdk_pkg::KEY_ENABLE, 3'b000});
    tick(200, 1'b0);
    pulse_cpu('{single_clr: 1'b1, default: 1'b0});
    tick(255, 1'b0);
    chk("no_reset_255", 32'h0, n_dev);
    tick(1, 1'b0);
    chk("reset_256", 32'h1, n_dev);
    rdchk("status_to", wdk_pkg::ADDR_STATUS, 32'h1);
    // Halt: power-down entry, overflow there gives only a warm reset
    pulse_cpu('{halt: 1'b1, default: 1'b0});
    rdchk("status_pd", wdk_pkg::ADDR_STATUS, 32'h6);
    src_sel <= wdk_pkg::SRC_INSTR;
    repeat (64) @(posedge clk);
    src_sel <= wdk_pkg::SRC_XTAL;
    rdchk("count_pd_instr", wdk_pkg::ADDR_COUNT, 32'h0);
    tick(256, 1'b0);
    chk("warm_pd", 32'h1, n_warm);
    chk("no_full_pd", 32'h1, n_dev);
    @(posedge clk);
    wake <= 1'b1;
    @(posedge clk);
    wake <= 1'b0;
    // Invalid key: flag at once, reset after the third slow tick
    wr(wdk_pkg::ADDR_KEYFLAGS, {5'h03, 3'b000});
    wb(1'b0, wdk_pkg::ADDR_KEYFLAGS, 32'h0, v);
    chk("key_reset_flag", 32'h1, {31'h0, v[0]});
    tick(2, 1'b1);
    chk("key_rst_early", 32'h1, n_dev);
    tick(1, 1'b1);
    chk("key_rst", 32'h2, n_dev);
    // Paired build ignores a lone clear; both halves clear it
    @(posedge clk);
    external_reset_pin_n <= 1'b0;
    @(posedge clk);
    external_reset_pin_n <= 1'b1;
    tick(32, 1'b0);
    pulse_cpu('{single_clr: 1'b1, default: 1'b0});
    pulse_cpu('{pair_first: 1'b1, default: 1'b0});
    rdchk("count_single", wdk_pkg::ADDR_COUNT, 32'h0);
    chk("p_count_half", 32'h2, pv);
    pulse_cpu('{pair_second: 1'b1, default: 1'b0});
    tick(16, 1'b0);
    rdchk("count_pair", wdk_pkg::ADDR_COUNT, 32'h1);
    chk("p_count_pair", 32'h1, pv);
    print_verdict();
  end
endmodule
